// ---- microcore_cond_jump_ctrl_fbk.v ----
`timescale 1ns/1ps
// Notes on behaviour
// - A taken absolute control-bit jump loads the program counter from the selected jump register.
// - A jump register address may point anywhere in code RAM.
// - A taken relative control-bit jump makes the relative target the next instruction.
// - The relative target is the jump instruction's own address plus the offset.
// - The offset is 5-bit two's complement, range -16 to 15.
// - The 4-bit control bit select picks bit 0 to bit 15 of the control word.
// - The tested bit comes from the core's own control word.
// - Active level 0 jumps on a 0 bit, 1 jumps on a 1 bit.
// - Absolute control-bit jump is 001111, level in 9, select in 8:5, jump register in 4, tail 0100.
// - Relative control-bit jump is 001000, level in 9, select in 8:5, offset in 4:0.
// - A taken feedback jump loads the program counter from the selected jump register.
// - Feedback codes 0 to 9 select high-side 1 to 5, even drain-source, odd source.
// - Feedback codes 10 to 15 select low-side 1 to 6 drain-source.
// - Absolute feedback jump is 001110, select in 8:5, jump register in 4, tail 0100.
`include "cond_jump_regs.vh"

module microcore_cond_jump_ctrl_fbk (
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire        instr_valid_in,
   input  wire [15:0] instr_in,
   input  wire [15:0] core_control_word_in,
   input  wire [9:0]  jump_register_0_in,
   input  wire [9:0]  jump_register_1_in,
   input  wire [4:0]  high_side_drain_source_fb_in,
   input  wire [4:0]  high_side_source_fb_in,
   input  wire [5:0]  low_side_drain_source_fb_in,
   output reg  [9:0]  program_counter_out,
   output reg         jump_taken_out
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   reg [1:0] rst_sync;
   wire      rst_n = rst_sync[1];

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   // ------------------------------------------------------------
   // Feedback synchronisers
   // ------------------------------------------------------------
   // Comparators are asynchronous; every line gets its own three-stage cell.
   // A lone glitch that never reaches two agreeing stages is ignored.
   wire [4:0] hs_ds_filt;
   wire [4:0] hs_src_filt;
   wire [5:0] ls_ds_filt;

   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : hs_sync
         fb_sync_cell u_hs_ds (
            .clk_in   (clk_in),
            .rst_n_in (rst_n),
            .raw_in   (high_side_drain_source_fb_in[g]),
            .filt_out (hs_ds_filt[g])
         );
         fb_sync_cell u_hs_src (
            .clk_in   (clk_in),
            .rst_n_in (rst_n),
            .raw_in   (high_side_source_fb_in[g]),
            .filt_out (hs_src_filt[g])
         );
      end
      for (g = 0; g < 6; g = g + 1) begin : ls_sync
         fb_sync_cell u_ls_ds (
            .clk_in   (clk_in),
            .rst_n_in (rst_n),
            .raw_in   (low_side_drain_source_fb_in[g]),
            .filt_out (ls_ds_filt[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Feedback select
   // ------------------------------------------------------------
   // Even codes pick drain-source, odd codes source feedback of one high-side
   // driver; the top six codes walk the low-side drivers in order.
   reg fbk_bit;

   always @* begin
      fbk_bit = 1'b0;
      case (instr_in[`SEL_HI:`SEL_LO])
         4'h0:    fbk_bit = hs_ds_filt[0];
         4'h1:    fbk_bit = hs_src_filt[0];
         4'h2:    fbk_bit = hs_ds_filt[1];
         4'h3:    fbk_bit = hs_src_filt[1];
         4'h4:    fbk_bit = hs_ds_filt[2];
         4'h5:    fbk_bit = hs_src_filt[2];
         4'h6:    fbk_bit = hs_ds_filt[3];
         4'h7:    fbk_bit = hs_src_filt[3];
         4'h8:    fbk_bit = hs_ds_filt[4];
         4'h9:    fbk_bit = hs_src_filt[4];
         4'ha:    fbk_bit = ls_ds_filt[0];
         4'hb:    fbk_bit = ls_ds_filt[1];
         4'hc:    fbk_bit = ls_ds_filt[2];
         4'hd:    fbk_bit = ls_ds_filt[3];
         4'he:    fbk_bit = ls_ds_filt[4];
         4'hf:    fbk_bit = ls_ds_filt[5];
         default: fbk_bit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire [5:0] opc      = instr_in[`OPC_HI:`OPC_LO];
   wire       is_cfar  = (opc == `OPC_CTRL_FAR) && (instr_in[3:0] == `FAR_TAIL);
   wire       is_crel  = (opc == `OPC_CTRL_REL);
   wire       is_ffar  = (opc == `OPC_FBK_FAR) && (instr_in[3:0] == `FAR_TAIL);
   wire       level    = instr_in[`POL_BIT];
   wire [3:0] sel      = instr_in[`SEL_HI:`SEL_LO];
   wire       ctrl_bit = core_control_word_in[sel];
   wire       ctrl_hit = (ctrl_bit == level);
   wire       fbk_hit  = (fbk_bit == level);
   wire [9:0] jreg     = instr_in[`JREG_BIT] ? jump_register_1_in : jump_register_0_in;
   wire [9:0] offset   = {{5{instr_in[`OFS_HI]}}, instr_in[`OFS_HI:`OFS_LO]};

   // Anything but the three forms, a far form with a wrong tail included, is a plain step
   localparam KIND_NONE     = 2'h0;
   localparam KIND_CTRL_FAR = 2'h1;
   localparam KIND_CTRL_REL = 2'h2;
   localparam KIND_FBK_FAR  = 2'h3;

   reg [1:0] jump_kind;

   always @* begin
      jump_kind = KIND_NONE;
      if (is_cfar)
         jump_kind = KIND_CTRL_FAR;
      else if (is_crel)
         jump_kind = KIND_CTRL_REL;
      else if (is_ffar)
         jump_kind = KIND_FBK_FAR;
   end

   wire [9:0] seq_target = program_counter_out + 10'h001;
   wire [9:0] rel_target = program_counter_out + offset;

   reg [9:0] next_program_counter;
   reg       next_jump_taken;

   always @* begin
      next_program_counter = program_counter_out;
      next_jump_taken      = 1'b0;
      if (instr_valid_in) begin
         next_program_counter = seq_target;
         case (jump_kind)
            KIND_CTRL_FAR: begin
               if (ctrl_hit) begin
                  next_program_counter = jreg;
                  next_jump_taken      = 1'b1;
               end
            end
            KIND_CTRL_REL: begin
               if (ctrl_hit) begin
                  // Wraps modulo code RAM size, like the sequential increment
                  next_program_counter = rel_target;
                  next_jump_taken      = 1'b1;
               end
            end
            KIND_FBK_FAR: begin
               if (fbk_hit) begin
                  next_program_counter = jreg;
                  next_jump_taken      = 1'b1;
               end
            end
            default: begin
               next_program_counter = seq_target;
               next_jump_taken      = 1'b0;
            end
         endcase
      end
   end

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         program_counter_out <= `PC_RESET;
         jump_taken_out      <= 1'b0;
      end else begin
         program_counter_out <= next_program_counter;
         jump_taken_out      <= next_jump_taken;
      end
   end

endmodule // microcore_cond_jump_ctrl_fbk

// ------------------------------------------------------------
// Feedback line synchroniser
// ------------------------------------------------------------
// Three stages against metastability; the output only follows once stages two
// and three agree, so a level must hold two clocks before it counts.
module fb_sync_cell (
   input  wire clk_in,
   input  wire rst_n_in,
   input  wire raw_in,
   output reg  filt_out
);

   reg stage_1;
   reg stage_2;
   reg stage_3;

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage_1  <= 1'b0;
         stage_2  <= 1'b0;
         stage_3  <= 1'b0;
         filt_out <= 1'b0;
      end else begin
         stage_1 <= raw_in;
         stage_2 <= stage_1;
         stage_3 <= stage_2;
         if (stage_2 == stage_3)
            filt_out <= stage_2;
      end
   end

endmodule // fb_sync_cell

// ---- cond_jump_regs.vh ----
`ifndef COND_JUMP_REGS_VH
`define COND_JUMP_REGS_VH

// Opcode fields, instruction bits 15:10
`define OPC_HI             15
`define OPC_LO             10
`define OPC_CTRL_FAR       6'h0f
`define OPC_CTRL_REL       6'h08
`define OPC_FBK_FAR        6'h0e
// Low nibble of the far forms
`define FAR_TAIL           4'h4
// Operand positions
`define POL_BIT            9
`define SEL_HI             8
`define SEL_LO             5
`define JREG_BIT           4
`define OFS_HI             4
`define OFS_LO             0
// Code RAM address width
`define PC_W               10
`define PC_RESET           10'h000
// Feedback select boundary between high-side and low-side codes
`define FBK_LS_FIRST       4'ha

`endif

// ---- cj_chk.sv ----
`timescale 1ns/1ps
module cj_chk (input wire clk_in, input wire rst_n_in, input wire instr_valid_in, input wire [15:0] instr_in,
   input wire [15:0] core_control_word_in, input wire [9:0] jump_register_0_in, input wire [9:0] jump_register_1_in,
   input wire [9:0] program_counter_out, input wire jump_taken_out);
   wire [5:0] op = instr_in[15:10];
   wire v = instr_valid_in;
   wire hit = v && core_control_word_in[instr_in[8:5]] == instr_in[9];
   wire far = instr_in[3:0] == 4'h4;
   wire jt = jump_taken_out;
   wire [9:0] pc = program_counter_out;
   wire [9:0] jr = instr_in[4] ? jump_register_1_in : jump_register_0_in;
   wire [9:0] rel = pc + {{5{instr_in[4]}}, instr_in[4:0]};
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_far_jump: assert property (hit && op == 6'h0f && far |=> jt && pc == $past(jr)) else $error("far");
   a_rel_jump: assert property (hit && op == 6'h08 |=> jt && pc == $past(rel)) else $error("rel");
   a_plain_step: assert property (v |=> jt || pc == $past(pc) + 10'h001) else $error("step");
   a_idle_hold: assert property (!v |=> $stable(pc) && !jt) else $error("idle");
   a_level_miss: assert property (v && !hit && op != 6'h0e |=> !jt) else $error("level");
   a_bad_tail: assert property (v && op == 6'h0f && !far |=> !jt) else $error("tail");
   a_fbk_dest: assert property (v && op == 6'h0e |=> !jt || pc == $past(jr)) else $error("fbk");
   a_other_op: assert property (v && op != 6'h0f && op != 6'h08 && op != 6'h0e |=> !jt) else $error("op");
endmodule // cj_chk

// ---- fb_model.sv ----
`timescale 1ns/1ps
module fb_model (
   input  wire [15:0] fb_in,
   output wire [4:0]  hs_ds_out,
   output wire [4:0]  hs_src_out,
   output wire [5:0]  ls_ds_out
);
   assign hs_ds_out = {fb_in[8], fb_in[6], fb_in[4], fb_in[2], fb_in[0]};
   assign hs_src_out = {fb_in[9], fb_in[7], fb_in[5], fb_in[3], fb_in[1]};
   assign ls_ds_out = fb_in[15:10];
endmodule // fb_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   reg         clk_in = 1'b0, rst_n_in = 1'b0, instr_valid_in = 1'b0;
   reg  [15:0] instr_in = 16'h0000, core_control_word_in = 16'h0000, fb = 16'h5a3c;
   reg  [9:0]  jump_register_0_in = 10'h2a5, jump_register_1_in = 10'h01c, mpc = 10'h000;
   wire [4:0]  high_side_drain_source_fb_in, high_side_source_fb_in;
   wire [5:0]  low_side_drain_source_fb_in;
   wire [9:0]  program_counter_out;
   wire        jump_taken_out;
   integer     miscompares = 0, total_checks = 0, k;
   reg  [31:0] rows [0:7];
   initial forever #2.5 clk_in = ~clk_in;
   fb_model u_fb (.fb_in(fb), .hs_ds_out(high_side_drain_source_fb_in), .hs_src_out(high_side_source_fb_in),
      .ls_ds_out(low_side_drain_source_fb_in));
   microcore_cond_jump_ctrl_fbk u_dut (.*);
   // One cycle per call; the model pc only moves on a valid slot
   task step(input v, input [15:0] i, input [15:0] w, input t);
      instr_valid_in = v;
      instr_in = i;
      core_control_word_in = w;
      if (v) mpc = !t ? mpc + 10'h001 : i[15:10] == 6'h08 ? mpc + {{5{i[4]}}, i[4:0]} : i[4] ? jump_register_1_in : jump_register_0_in;
      @(negedge clk_in);
      total_checks = total_checks + 1;
      if ({jump_taken_out, program_counter_out} !== {t, mpc}) begin
         miscompares = miscompares + 1;
         $display("wrong value at %0t: %h expected %h", $time, {jump_taken_out, program_counter_out}, {t, mpc});
      end
   endtask
   task tally_and_finish;
      if (miscompares == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      rows = '{32'h3e640008, 32'h3df47fff, 32'h220f0001, 32'h22100001,
               32'h22100000, 32'h3e650008, 32'h3a05ffff, 32'h0000ffff};
      // Sixteen cycles in reset, then idle slots while the internal reset drains
      for (k = 0; k < 20; k = k + 1) begin
         rst_n_in = k >= 16;
         step(1'b0, 16'h0000, 16'h0000, 1'b0);
      end
      for (k = 0; k < 8; k = k + 1) step(1'b1, rows[k][31:16], rows[k][15:0], k < 4);
      for (k = 0; k < 32; k = k + 1) step(1'b1, {5'h07, k[0], k[1], k[4:1], k[2], 4'h4}, fb, fb[k[4:1]] == k[1]);
      // A feedback change counts only once it has crossed the synchroniser
      fb = 16'h5e3c;
      for (k = 0; k < 5; k = k + 1) step(1'b1, 16'h3b44, 16'h0000, k == 4);
      // Reset in mid-run clears counter and flag at once
      rst_n_in = 1'b0;
      mpc = 10'h000;
      step(1'b0, 16'h0000, 16'h0000, 1'b0);
      rst_n_in = 1'b1;
      for (k = 0; k < 2; k = k + 1) step(1'b0, 16'h0000, 16'h0000, 1'b0);
      step(1'b1, 16'h3e64, 16'h0008, 1'b1);
      step(1'b0, 16'h0000, fb, 1'b0);
      tally_and_finish;
   end
endmodule // tb
bind microcore_cond_jump_ctrl_fbk cj_chk u_chk (.*);
